// [logic/branch_exec_pkg.sv]
`default_nettype none
package branch_exec_pkg;

	// Bit positions inside the 16-bit flags word
	localparam int unsigned FLAG_CARRY = 0;
	localparam int unsigned FLAG_ZERO = 6;
	localparam int unsigned FLAG_TRAP = 8;
	localparam int unsigned FLAG_INTEN = 9;
	localparam int unsigned FLAG_OVF = 11;

	// Fixed pointer words of the overflow trap (type 4 times four)
	localparam logic [15:0] TRAP_OFS_ADDR = 16'h0010;
	localparam logic [15:0] TRAP_CS_ADDR = 16'h0012;

	// One stack word is two bytes
	localparam logic [15:0] STACK_STEP = 16'h0002;

	// Values after reset
	localparam logic [15:0] RESET_WORD = 16'h0000;

	// Instruction kinds; the aliases of each branch share one kind
	typedef enum logic [2:0] {
		OP_NONE,
		OP_INTERRUPT_ON_OVERFLOW,
		OP_INTERRUPT_RETURN,
		OP_BRANCH_IF_ABOVE,
		OP_BRANCH_IF_ABOVE_OR_EQUAL,
		OP_BRANCH_IF_BELOW,
		OP_BRANCH_IF_BELOW_OR_EQUAL
	} op_t;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_PUSH_FLAGS,
		ST_PUSH_CS,
		ST_LOAD_CS,
		ST_PUSH_PTR,
		ST_LOAD_PTR,
		ST_POP_PTR,
		ST_POP_CS,
		ST_POP_FLAGS
	} exec_state_t;

	// Architectural words the block reads and returns
	typedef struct packed {
		logic [15:0] iptr;
		logic [15:0] cs;
		logic [15:0] sptr;
		logic [15:0] flags;
	} arch_t;

	// One decoded instruction handed over by decode
	typedef struct packed {
		op_t op;
		logic [7:0] disp;
		arch_t arch;
	} exec_req_t;

	// Sign extension of a short displacement
	function automatic logic [15:0] sext8(input logic [7:0] v);
		return {{8{v[7]}}, v};
	endfunction

endpackage
`default_nettype wire

// [logic/short_target_adder.sv]
`timescale 1ns/1ps
`default_nettype none
// Branch target: following address plus sign-extended displacement
module short_target_adder (
	input wire logic [15:0] base,
	input wire logic [7:0] disp,
	output logic [15:0] target
);

	// Wraps modulo 64K like the real pointer
	assign target = base + branch_exec_pkg::sext8(disp);

endmodule
`default_nettype wire

// [logic/branch_condition.sv]
`timescale 1ns/1ps
`default_nettype none
// Carry/zero condition of the short branches
module branch_condition (
	input wire branch_exec_pkg::op_t op,
	input wire logic [15:0] flags,
	output logic taken
);

	logic carry;
	logic zero;

	// Pick the two flags the conditions look at
	assign carry = flags[branch_exec_pkg::FLAG_CARRY];
	assign zero = flags[branch_exec_pkg::FLAG_ZERO];

	// Kinds that are not branches are never taken
	always_comb
	begin
		case (op)
			branch_exec_pkg::OP_BRANCH_IF_ABOVE: taken = !carry || !zero;
			branch_exec_pkg::OP_BRANCH_IF_ABOVE_OR_EQUAL: taken = !carry;
			branch_exec_pkg::OP_BRANCH_IF_BELOW: taken = carry;
			branch_exec_pkg::OP_BRANCH_IF_BELOW_OR_EQUAL: taken = carry || zero;
			default: taken = 1'b0;
		endcase
	end

endmodule
`default_nettype wire

// [logic/branch_and_interrupt_exec.sv]
// What this block does
// - Overflow trap with overflow flag clear just completes; no stack traffic.
// - Overflow flag set: trap is type 4, pointer fetched at 10H.
// - Taken trap clears trap and interrupt-enable flags after flags are saved.
// - Push flags, push code segment, load it from 12H, push pointer, load it from 10H.
// - Return pops instruction pointer, code segment, flags; each pop reads then adds two.
// - Return replaces every flag; exits any interrupt procedure.
// - Taken short branch adds sign-extended 8-bit displacement to instruction pointer.
// - Branch-if-above taken when carry clear or zero clear.
// - Branch-if-above-or-equal taken exactly when carry clear.
// - Branch-if-below and branch-if-carry-set taken exactly when carry set.
// - Branch-if-below-or-equal taken when carry set or zero set.
// - Short branches leave every flag unchanged.
`timescale 1ns/1ps
`default_nettype none
module branch_and_interrupt_exec (
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	input wire branch_exec_pkg::exec_req_t req,
	output logic ready,
	output logic done,
	output logic taken,
	output branch_exec_pkg::arch_t result,
	output logic mem_req,
	output logic mem_we,
	output logic mem_abs,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ack
);

	branch_exec_pkg::exec_state_t st_q, st_d;
	branch_exec_pkg::arch_t arch_q, arch_d;
	logic ready_q, ready_d;
	logic done_q, done_d;
	logic taken_q, taken_d;
	logic req_q, req_d;
	logic we_q, we_d;
	logic abs_q, abs_d;
	logic [15:0] addr_q, addr_d;
	logic [15:0] wdata_q, wdata_d;
	logic [15:0] target;
	logic cond_taken;
	logic accept;

	// Target and condition come from the incoming request, so a branch finishes in one cycle
	short_target_adder i_short_target_adder (
		.base(req.arch.iptr),
		.disp(req.disp),
		.target(target)
	);

	branch_condition i_branch_condition (
		.op(req.op),
		.flags(req.arch.flags),
		.taken(cond_taken)
	);

	// A request is only looked at while idle; start while busy is dropped
	assign accept = start && ready_q;

	// Sequencer: one memory word per state, request held until acknowledged
	always_comb
	begin
		st_d = st_q;
		arch_d = arch_q;
		done_d = 1'b0;
		taken_d = taken_q;
		req_d = req_q;
		we_d = we_q;
		abs_d = abs_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		case (st_q)
			branch_exec_pkg::ST_IDLE:
			begin
				if (accept)
				begin
					arch_d = req.arch;
					case (req.op)
						branch_exec_pkg::OP_INTERRUPT_ON_OVERFLOW:
						begin
							taken_d = req.arch.flags[branch_exec_pkg::FLAG_OVF];
							if (req.arch.flags[branch_exec_pkg::FLAG_OVF])
								st_d = branch_exec_pkg::ST_PUSH_FLAGS;
							else
								done_d = 1'b1;
						end
						branch_exec_pkg::OP_INTERRUPT_RETURN:
						begin
							taken_d = 1'b1;
							st_d = branch_exec_pkg::ST_POP_PTR;
						end
						branch_exec_pkg::OP_BRANCH_IF_ABOVE,
						branch_exec_pkg::OP_BRANCH_IF_ABOVE_OR_EQUAL,
						branch_exec_pkg::OP_BRANCH_IF_BELOW,
						branch_exec_pkg::OP_BRANCH_IF_BELOW_OR_EQUAL:
						begin
							// Flags pass through untouched either way
							taken_d = cond_taken;
							if (cond_taken)
								arch_d.iptr = target;
							done_d = 1'b1;
						end
						default:
						begin
							taken_d = 1'b0;
							done_d = 1'b1;
						end
					endcase
				end
			end
			branch_exec_pkg::ST_PUSH_FLAGS:
			begin
				if (!req_q)
				begin
					arch_d.sptr = arch_q.sptr - branch_exec_pkg::STACK_STEP;
					req_d = 1'b1;
					we_d = 1'b1;
					abs_d = 1'b0;
					addr_d = arch_q.sptr - branch_exec_pkg::STACK_STEP;
					wdata_d = arch_q.flags;
				end
				else if (mem_ack)
				begin
					// Cleared only once the old word is safely on the stack
					req_d = 1'b0;
					arch_d.flags[branch_exec_pkg::FLAG_TRAP] = 1'b0;
					arch_d.flags[branch_exec_pkg::FLAG_INTEN] = 1'b0;
					st_d = branch_exec_pkg::ST_PUSH_CS;
				end
			end
			branch_exec_pkg::ST_PUSH_CS:
			begin
				if (!req_q)
				begin
					arch_d.sptr = arch_q.sptr - branch_exec_pkg::STACK_STEP;
					req_d = 1'b1;
					we_d = 1'b1;
					abs_d = 1'b0;
					addr_d = arch_q.sptr - branch_exec_pkg::STACK_STEP;
					wdata_d = arch_q.cs;
				end
				else if (mem_ack)
				begin
					req_d = 1'b0;
					st_d = branch_exec_pkg::ST_LOAD_CS;
				end
			end
			branch_exec_pkg::ST_LOAD_CS:
			begin
				if (!req_q)
				begin
					req_d = 1'b1;
					we_d = 1'b0;
					abs_d = 1'b1;
					addr_d = branch_exec_pkg::TRAP_CS_ADDR;
				end
				else if (mem_ack)
				begin
					req_d = 1'b0;
					arch_d.cs = mem_rdata;
					st_d = branch_exec_pkg::ST_PUSH_PTR;
				end
			end
			branch_exec_pkg::ST_PUSH_PTR:
			begin
				if (!req_q)
				begin
					arch_d.sptr = arch_q.sptr - branch_exec_pkg::STACK_STEP;
					req_d = 1'b1;
					we_d = 1'b1;
					abs_d = 1'b0;
					addr_d = arch_q.sptr - branch_exec_pkg::STACK_STEP;
					wdata_d = arch_q.iptr;
				end
				else if (mem_ack)
				begin
					req_d = 1'b0;
					st_d = branch_exec_pkg::ST_LOAD_PTR;
				end
			end
			branch_exec_pkg::ST_LOAD_PTR:
			begin
				if (!req_q)
				begin
					req_d = 1'b1;
					we_d = 1'b0;
					abs_d = 1'b1;
					addr_d = branch_exec_pkg::TRAP_OFS_ADDR;
				end
				else if (mem_ack)
				begin
					req_d = 1'b0;
					arch_d.iptr = mem_rdata;
					done_d = 1'b1;
					st_d = branch_exec_pkg::ST_IDLE;
				end
			end
			branch_exec_pkg::ST_POP_PTR,
			branch_exec_pkg::ST_POP_CS,
			branch_exec_pkg::ST_POP_FLAGS:
			begin
				// Read at the pointer first, bump it only after the word arrives
				if (!req_q)
				begin
					req_d = 1'b1;
					we_d = 1'b0;
					abs_d = 1'b0;
					addr_d = arch_q.sptr;
				end
				else if (mem_ack)
				begin
					req_d = 1'b0;
					arch_d.sptr = arch_q.sptr + branch_exec_pkg::STACK_STEP;
					if (st_q == branch_exec_pkg::ST_POP_PTR)
					begin
						arch_d.iptr = mem_rdata;
						st_d = branch_exec_pkg::ST_POP_CS;
					end
					else if (st_q == branch_exec_pkg::ST_POP_CS)
					begin
						arch_d.cs = mem_rdata;
						st_d = branch_exec_pkg::ST_POP_FLAGS;
					end
					else
					begin
						arch_d.flags = mem_rdata;
						done_d = 1'b1;
						st_d = branch_exec_pkg::ST_IDLE;
					end
				end
			end
			default:
			begin
				req_d = 1'b0;
				st_d = branch_exec_pkg::ST_IDLE;
			end
		endcase
		ready_d = (st_d == branch_exec_pkg::ST_IDLE);
	end

	// State registers only
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q <= branch_exec_pkg::ST_IDLE;
			arch_q <= {4{branch_exec_pkg::RESET_WORD}};
			ready_q <= 1'b1;
			done_q <= 1'b0;
			taken_q <= 1'b0;
			req_q <= 1'b0;
			we_q <= 1'b0;
			abs_q <= 1'b0;
			addr_q <= branch_exec_pkg::RESET_WORD;
			wdata_q <= branch_exec_pkg::RESET_WORD;
		end
		else
		begin
			st_q <= st_d;
			arch_q <= arch_d;
			ready_q <= ready_d;
			done_q <= done_d;
			taken_q <= taken_d;
			req_q <= req_d;
			we_q <= we_d;
			abs_q <= abs_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
		end
	end

	// Every output is a flop
	assign ready = ready_q;
	assign done = done_q;
	assign taken = taken_q;
	assign result = arch_q;
	assign mem_req = req_q;
	assign mem_we = we_q;
	assign mem_abs = abs_q;
	assign mem_addr = addr_q;
	assign mem_wdata = wdata_q;

	// Checks on the sequencer
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	logic start_trap, start_ret, start_br;
	assign start_trap = accept && req.op == branch_exec_pkg::OP_INTERRUPT_ON_OVERFLOW;
	assign start_ret = accept && req.op == branch_exec_pkg::OP_INTERRUPT_RETURN;
	assign start_br = accept && (req.op == branch_exec_pkg::OP_BRANCH_IF_ABOVE
		|| req.op == branch_exec_pkg::OP_BRANCH_IF_ABOVE_OR_EQUAL
		|| req.op == branch_exec_pkg::OP_BRANCH_IF_BELOW
		|| req.op == branch_exec_pkg::OP_BRANCH_IF_BELOW_OR_EQUAL);

	AST_NO_OVF_QUIET: assert property (start_trap
		&& !req.arch.flags[branch_exec_pkg::FLAG_OVF]
		|=> done_q && !taken_q && !req_q && result.iptr == $past(req.arch.iptr))
		else $error("trap without overflow did not complete quietly");
	AST_TRAP_VECTOR: assert property (st_q == branch_exec_pkg::ST_LOAD_PTR && req_q
		|-> abs_q && !we_q && addr_q == branch_exec_pkg::TRAP_OFS_ADDR)
		else $error("trap pointer not read at fixed word");
	AST_TRAP_CLEARS: assert property (st_q == branch_exec_pkg::ST_PUSH_FLAGS && req_q
		&& mem_ack |=> !result.flags[branch_exec_pkg::FLAG_TRAP]
		&& !result.flags[branch_exec_pkg::FLAG_INTEN])
		else $error("trap and enable flags not cleared");
	AST_TRAP_FIRST_PUSH: assert property (start_trap
		&& req.arch.flags[branch_exec_pkg::FLAG_OVF]
		|=> ##1 req_q && we_q && wdata_q == $past(req.arch.flags, 2)
		&& addr_q == $past(req.arch.sptr, 2) - branch_exec_pkg::STACK_STEP)
		else $error("flags not pushed first below the stack pointer");
	AST_POP_ORDER: assert property (start_ret |=> ##1 req_q && !we_q && !abs_q
		&& addr_q == $past(req.arch.sptr, 2))
		else $error("return did not read at the stack pointer");
	AST_RET_FLAGS: assert property (st_q == branch_exec_pkg::ST_POP_FLAGS && req_q && mem_ack
		|=> done_q && result.flags == $past(mem_rdata) && ready_q)
		else $error("return did not restore flags");
	AST_BRANCH_ADD: assert property (start_br && cond_taken
		|=> done_q && taken_q
		&& result.iptr == $past(req.arch.iptr) + branch_exec_pkg::sext8($past(req.disp)))
		else $error("branch target wrong");
	AST_ABOVE: assert property (accept && req.op == branch_exec_pkg::OP_BRANCH_IF_ABOVE
		|=> taken_q == ($past(!req.arch.flags[branch_exec_pkg::FLAG_CARRY])
		|| $past(!req.arch.flags[branch_exec_pkg::FLAG_ZERO])))
		else $error("above condition wrong");
	AST_ABOVE_EQ: assert property (accept
		&& req.op == branch_exec_pkg::OP_BRANCH_IF_ABOVE_OR_EQUAL
		|=> taken_q == !$past(req.arch.flags[branch_exec_pkg::FLAG_CARRY]))
		else $error("above-or-equal condition wrong");
	AST_BELOW: assert property (accept && req.op == branch_exec_pkg::OP_BRANCH_IF_BELOW
		|=> taken_q == $past(req.arch.flags[branch_exec_pkg::FLAG_CARRY]))
		else $error("below condition wrong");
	AST_BELOW_EQ: assert property (accept
		&& req.op == branch_exec_pkg::OP_BRANCH_IF_BELOW_OR_EQUAL
		|=> taken_q == ($past(req.arch.flags[branch_exec_pkg::FLAG_CARRY])
		|| $past(req.arch.flags[branch_exec_pkg::FLAG_ZERO])))
		else $error("below-or-equal condition wrong");
	AST_BRANCH_FLAGS: assert property (start_br |=> result.flags == $past(req.arch.flags)
		&& result.sptr == $past(req.arch.sptr) && !req_q)
		else $error("branch disturbed flags or stack");
	AST_NOT_TAKEN_PTR: assert property (start_br && !cond_taken
		|=> done_q && !taken_q && result.iptr == $past(req.arch.iptr))
		else $error("untaken branch moved the pointer");

	COV_TRAP: cover property (st_q == branch_exec_pkg::ST_LOAD_PTR && mem_ack && req_q);
	COV_RETURN: cover property (st_q == branch_exec_pkg::ST_POP_FLAGS && mem_ack && req_q);
	COV_BR_TAKEN: cover property (start_br && cond_taken);
	COV_BR_NOT: cover property (start_br && !cond_taken);

endmodule
`default_nettype wire

// [test/branch_and_interrupt_exec_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module branch_and_interrupt_exec_bench;
	logic clk;
	logic nrst;
	logic start;
	logic ready;
	logic done;
	logic taken;
	logic mem_req;
	logic mem_we;
	logic mem_abs;
	logic mem_ack;
	logic [15:0] mem_addr;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;
	branch_exec_pkg::exec_req_t req;
	branch_exec_pkg::arch_t result;
	int num_errors;
	int samples_checked;

	branch_and_interrupt_exec i_branch_and_interrupt_exec (
		.clk(clk),
		.nrst(nrst),
		.start(start),
		.req(req),
		.ready(ready),
		.done(done),
		.taken(taken),
		.result(result),
		.mem_req(mem_req),
		.mem_we(mem_we),
		.mem_abs(mem_abs),
		.mem_addr(mem_addr),
		.mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata),
		.mem_ack(mem_ack)
	);

	// Core clock, 100 ns period
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hand one instruction over; start drops at the next falling edge
	task automatic launch(input branch_exec_pkg::op_t op, input logic [7:0] disp,
		input branch_exec_pkg::arch_t arch);
		@(negedge clk);
		req.op = op;
		req.disp = disp;
		req.arch = arch;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
	endtask

	// Done must be seen at the present falling edge or within the n falling edges after it
	task automatic wait_done(input int n);
		int i;
		i = 0;
		while (done !== 1'b1 && i < n)
		begin
			@(negedge clk);
			i++;
		end
		if (done !== 1'b1)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, done, 1'b1);
			end_sim();
		end
	endtask

	// Answer one memory word after lag cycles; data bus shows junk when idle
	task automatic mem_word(input logic we, input logic abs, input logic [15:0] addr,
		input logic [15:0] wdata, input logic [15:0] rdata, input int lag);
		int i;
		i = 0;
		while (mem_req !== 1'b1 && i < 20)
		begin
			@(negedge clk);
			i++;
		end
		if (mem_req !== 1'b1)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, mem_req, 1'b1);
			end_sim();
		end
		check({mem_we, mem_abs, mem_addr}, {we, abs, addr});
		if (we)
			check(mem_wdata, wdata);
		repeat (lag) @(negedge clk);
		check({mem_req, mem_addr}, {1'b1, addr});
		mem_rdata = rdata;
		mem_ack = 1'b1;
		@(negedge clk);
		mem_ack = 1'b0;
		mem_rdata = ~rdata;
		check(mem_req, 1'b0);
	endtask

	// Every branch kind against every carry/zero pair, both signs of offset
	task automatic test_branches;
		branch_exec_pkg::op_t ops[4];
		branch_exec_pkg::arch_t a;
		branch_exec_pkg::arch_t e;
		logic carry;
		logic zero;
		logic t;
		logic [7:0] d;
		ops = '{branch_exec_pkg::OP_BRANCH_IF_ABOVE, branch_exec_pkg::OP_BRANCH_IF_ABOVE_OR_EQUAL,
			branch_exec_pkg::OP_BRANCH_IF_BELOW, branch_exec_pkg::OP_BRANCH_IF_BELOW_OR_EQUAL};
		for (int o = 0; o < 4; o++)
			for (int k = 0; k < 4; k++)
			begin
				carry = k[0];
				zero = k[1];
				d = k[0] ? 8'h80 : 8'h7F;
				a = '{iptr: 16'h0010, cs: 16'h2000, sptr: 16'h0300, flags: 16'h0B00};
				a.flags[branch_exec_pkg::FLAG_CARRY] = carry;
				a.flags[branch_exec_pkg::FLAG_ZERO] = zero;
				case (o)
					0: t = !carry || !zero;
					1: t = !carry;
					2: t = carry;
					default: t = carry || zero;
				endcase
				e = a;
				if (t)
					e.iptr = a.iptr + {{8{d[7]}}, d};
				launch(ops[o], d, a);
				wait_done(1);
				check(taken, t);
				check(result, e);
			end
		$display("Branch test finished");
	endtask

	// Overflow clear and the no-op kind: both fall through with no stack traffic
	task automatic test_trap_clear;
		branch_exec_pkg::arch_t a;
		a = '{iptr: 16'h0456, cs: 16'h1234, sptr: 16'h0100, flags: 16'h0300};
		launch(branch_exec_pkg::OP_INTERRUPT_ON_OVERFLOW, 8'h00, a);
		wait_done(1);
		check({taken, mem_req}, 2'h0);
		check(result, a);
		// Done is a one-cycle pulse and the block is idle again at once
		@(negedge clk);
		check({done, ready}, 2'h1);
		launch(branch_exec_pkg::OP_NONE, 8'h55, a);
		wait_done(1);
		check({taken, mem_req}, 2'h0);
		check(result, a);
		$display("Untaken trap test finished");
	endtask

	// Overflow set: five words in order, slow answers on some
	task automatic test_trap_set;
		branch_exec_pkg::arch_t a;
		branch_exec_pkg::arch_t e;
		a = '{iptr: 16'h0456, cs: 16'h1234, sptr: 16'h0100, flags: 16'h0BD5};
		e = '{iptr: 16'h0040, cs: 16'hA000, sptr: 16'h00FA, flags: 16'h08D5};
		launch(branch_exec_pkg::OP_INTERRUPT_ON_OVERFLOW, 8'h00, a);
		check(ready, 1'b0);
		mem_word(1'b1, 1'b0, 16'h00FE, 16'h0BD5, 16'h0000, 0);
		// A start while busy must be dropped, or the word order below breaks
		start = 1'b1;
		mem_word(1'b1, 1'b0, 16'h00FC, 16'h1234, 16'h0000, 2);
		start = 1'b0;
		mem_word(1'b0, 1'b1, 16'h0012, 16'h0000, 16'hA000, 1);
		mem_word(1'b1, 1'b0, 16'h00FA, 16'h0456, 16'h0000, 0);
		mem_word(1'b0, 1'b1, 16'h0010, 16'h0000, 16'h0040, 3);
		wait_done(1);
		check(taken, 1'b1);
		check(result, e);
		$display("Taken trap test finished");
	endtask

	// Return pops three words and replaces every flag
	task automatic test_return;
		branch_exec_pkg::arch_t a;
		branch_exec_pkg::arch_t e;
		a = '{iptr: 16'h7777, cs: 16'h5555, sptr: 16'h00FA, flags: 16'h0000};
		e = '{iptr: 16'h0456, cs: 16'h1234, sptr: 16'h0100, flags: 16'hFFD5};
		launch(branch_exec_pkg::OP_INTERRUPT_RETURN, 8'h00, a);
		mem_word(1'b0, 1'b0, 16'h00FA, 16'h0000, 16'h0456, 1);
		mem_word(1'b0, 1'b0, 16'h00FC, 16'h0000, 16'h1234, 0);
		mem_word(1'b0, 1'b0, 16'h00FE, 16'h0000, 16'hFFD5, 2);
		wait_done(1);
		check(result, e);
		check(taken, 1'b1);
		$display("Return test finished");
	endtask

	// Main sequence: reset for ten cycles, then each scenario
	initial
	begin
		num_errors = 0;
		samples_checked = 0;
		nrst = 1'b0;
		start = 1'b0;
		req = '0;
		mem_ack = 1'b0;
		mem_rdata = 16'hFFFF;
		repeat (10) @(negedge clk);
		check({ready, done, mem_req}, 3'h4);
		nrst = 1'b1;
		test_branches();
		test_trap_clear();
		test_trap_set();
		test_return();
		end_sim();
	end
endmodule
`default_nettype wire
